// >>> encoder_phasing_sequencer.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module encoder_phasing_sequencer
  import enc_phase_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // drive condition
  input  wire logic        hardware_enable_bit,
  input  wire logic [15:0] fault_code,
  input  wire logic        drive_ready,
  input  wire logic        inrush_closed,
  input  wire logic        low_voltage_mode,
  // motion request and feedback
  output logic             motion_start,
  output logic [1:0]       motion_kind,
  output logic [15:0]      motion_param,
  input  wire logic        motion_done,
  input  wire logic [31:0] enc_delta,
  input  wire logic [15:0] vib_torque_time,
  // results
  output logic             emu_zero_reset,
  output logic             commutation_valid,
  output logic             drive_ok_flag,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [CTRL_W-1:0] ctrl;
  logic [15:0]       primary_encoder_line_count;
  logic [15:0]       aux_encoder_line_count;
  logic [15:0]       motor_pole_count;
  logic [15:0]       phasing_result_code;
  logic [15:0]       torque_timing_value;
  logic [15:0]       torque_saved;
  logic              torque_saved_valid;
  logic              type1_outcome_flag;
  logic              type2_outcome_flag;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  seq_state_e        state;
  logic              run_type2;
  logic [15:0]       next_code;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic [IRQ_W-1:0]  ev;
  logic [15:0]       sel_lines;
  logic              sel_fmt;
  logic [31:0]       eff_delta;
  logic [15:0]       torq_diff;

  // line count unusable: zero, or exponent outside range
  function automatic logic line_bad(input logic [15:0] v, input logic fmt);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : v;
    line_bad = (mag == 16'h0000) || (fmt && (mag > EXP_MAX));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFF_IRQ_MASK);
  assign pslverr = psel & penable & ~addr_ok;

  // read data captured in setup phase, valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        OFF_CTRL:       prdata <= {25'h0, ctrl};
        OFF_PRI_LINES:  prdata <= {16'h0, primary_encoder_line_count};
        OFF_AUX_LINES:  prdata <= {16'h0, aux_encoder_line_count};
        OFF_POLES:      prdata <= {16'h0, motor_pole_count};
        OFF_RESULT:     prdata <= {16'h0, phasing_result_code};
        OFF_STATUS:     prdata <= {25'h0, commutation_valid,
                                   torque_saved_valid, hardware_enable_bit,
                                   ~state[0], drive_ok_flag,
                                   type2_outcome_flag, type1_outcome_flag};
        OFF_TORQ_CALC:  prdata <= {16'h0, torque_timing_value};
        OFF_TORQ_SAVED: prdata <= {16'h0, torque_saved};
        OFF_IRQ_STAT:   prdata <= {29'h0, irq_stat};
        OFF_IRQ_MASK:   prdata <= {29'h0, irq_mask};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_encoder_line_count <= LINE_RESET;
      aux_encoder_line_count     <= LINE_RESET;
      motor_pole_count           <= POLES_RESET;
      irq_mask                   <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFF_PRI_LINES: primary_encoder_line_count <= pwdata[15:0];
        OFF_AUX_LINES: aux_encoder_line_count     <= pwdata[15:0];
        OFF_POLES:     motor_pole_count           <= pwdata[15:0];
        OFF_IRQ_MASK:  irq_mask                   <= pwdata[IRQ_W-1:0];
        default:       ;
      endcase
    end
  end

  // control bits; commands are cleared by the sequencer at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else begin
      if (wr_en && paddr == OFF_CTRL) begin
        ctrl <= pwdata[CTRL_W-1:0];
        ctrl[CB_SAVE] <= 1'b0;
      end
      if (state == ST_DONE) begin
        ctrl[CB_CMD1] <= 1'b0;
        ctrl[CB_CMD2] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // feedback source and sign-corrected displacement
  assign sel_lines = ctrl[CB_SRC] ? aux_encoder_line_count
                                  : primary_encoder_line_count;
  assign sel_fmt   = ctrl[CB_SRC] ? ctrl[CB_AFMT] : ctrl[CB_PFMT];
  assign eff_delta = sel_lines[15] ? 32'(-enc_delta) : enc_delta;
  assign torq_diff = (vib_torque_time > torque_saved)
                   ? 16'(vib_torque_time - torque_saved)
                   : 16'(torque_saved - vib_torque_time);

  // result code for the step being left
  always_comb begin
    next_code = RC_OK;
    case (state)
      ST_CHECK: begin
        if (ctrl[CB_SWEN] || !hardware_enable_bit)
          next_code = RC_ENABLE;
        else if (fault_code != 16'h0000 || !drive_ready || !inrush_closed ||
                 low_voltage_mode)
          next_code = RC_NOTREADY;
        else if (!run_type2 &&
                 (motor_pole_count == 16'h0000 ||
                  line_bad(primary_encoder_line_count, ctrl[CB_PFMT]) ||
                  line_bad(aux_encoder_line_count, ctrl[CB_AFMT])))
          next_code = RC_COUNT;
      end
      ST_MOVE2: begin
        if (eff_delta[31])
          next_code = RC_POSFB;
        else if (eff_delta == 32'h0000_0000 || line_bad(sel_lines, sel_fmt))
          next_code = RC_COUNT;
      end
      ST_VIB: begin
        if (vib_torque_time > TORQ_MAX)
          next_code = RC_OVER;
        else if (torque_saved_valid && torq_diff > TORQ_DEV_MAX)
          next_code = RC_DEVIATE;
      end
      default: next_code = RC_OK;
    endcase
  end

  // state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      run_type2 <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ctrl[CB_CMD1] || ctrl[CB_CMD2]) begin
            run_type2 <= ~ctrl[CB_CMD1] & ctrl[CB_CMD2];
            state     <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (next_code != RC_OK)
            state <= ST_DONE;
          else
            state <= run_type2 ? ST_VIB : ST_MOVE1;
        end
        ST_MOVE1: if (motion_done) state <= ST_MOVE2;
        ST_MOVE2: if (motion_done) state <= ST_DONE;
        ST_VIB:   if (motion_done) state <= ST_DONE;
        ST_DONE:  state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // result code from a refused check or from each finished move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phasing_result_code <= RC_OK;
    end else if (state == ST_CHECK && next_code != RC_OK) begin
      phasing_result_code <= next_code;
    end else if ((state == ST_MOVE2 || state == ST_VIB) && motion_done) begin
      phasing_result_code <= next_code;
    end else if (state == ST_MOVE1 && motion_done) begin
      phasing_result_code <= RC_OK;
    end
  end

  // motion request pulses toward the current loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_start <= 1'b0;
      motion_kind  <= MK_NONE;
      motion_param <= ANGLE_ZERO;
    end else begin
      motion_start <= 1'b0;
      if (state == ST_CHECK && next_code == RC_OK) begin
        motion_start <= 1'b1;
        motion_kind  <= run_type2 ? MK_VIBRATE : MK_ALIGN;
        motion_param <= (run_type2 && torque_saved_valid) ? torque_saved
                                                          : ANGLE_ZERO;
      end else if (state == ST_MOVE1 && motion_done) begin
        motion_start <= 1'b1;
        motion_kind  <= MK_QUARTER;
        motion_param <= ANGLE_QTR;
      end else if (state == ST_DONE) begin
        motion_kind  <= MK_NONE;
      end
    end
  end

  // emulated encoder zero re-armed whenever a command is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      emu_zero_reset <= 1'b0;
    else
      emu_zero_reset <= (state == ST_IDLE) &&
                        (ctrl[CB_CMD1] || ctrl[CB_CMD2]);
  end

  // outcome flags; a new attempt of a type clears its flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type1_outcome_flag <= 1'b0;
      type2_outcome_flag <= 1'b0;
    end else if (state == ST_CHECK) begin
      if (run_type2)
        type2_outcome_flag <= 1'b0;
      else
        type1_outcome_flag <= 1'b0;
    end else if (motion_done && next_code == RC_OK) begin
      if (state == ST_MOVE2)
        type1_outcome_flag <= 1'b1;
      if (state == ST_VIB)
        type2_outcome_flag <= 1'b1;
    end
  end

  // measured torque timing and the saved copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_timing_value <= 16'h0000;
      torque_saved        <= 16'h0000;
      torque_saved_valid  <= 1'b0;
    end else begin
      if (state == ST_VIB && motion_done)
        torque_timing_value <= vib_torque_time;
      if (wr_en && paddr == OFF_CTRL && pwdata[CB_SAVE] &&
          !hardware_enable_bit) begin
        torque_saved       <= torque_timing_value;
        torque_saved_valid <= 1'b1;
      end
    end
  end

  // commutation and drive ok gating
  assign commutation_valid = type1_outcome_flag | type2_outcome_flag;
  assign drive_ok_flag = type1_outcome_flag && type2_outcome_flag &&
                         hardware_enable_bit && fault_code == 16'h0000 &&
                         drive_ready;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, set wins

  assign ev[IB_DONE1] = state == ST_MOVE2 && motion_done && next_code == RC_OK;
  assign ev[IB_DONE2] = state == ST_VIB && motion_done && next_code == RC_OK;
  assign ev[IB_FAIL]  = state == ST_DONE && phasing_result_code != RC_OK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat <= '0;
    else if (wr_en && paddr == OFF_IRQ_STAT)
      irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | ev;
    else
      irq_stat <= irq_stat | ev;
  end

  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_take;
    state == ST_IDLE && (ctrl[CB_CMD1] || ctrl[CB_CMD2]);
  endsequence

  sequence s_t1_success;
    state == ST_MOVE2 && motion_done && next_code == RC_OK;
  endsequence

  AST_ZERO_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    s_take |=> emu_zero_reset)
    else $error("zero reference not re-armed on command");

  AST_ENABLE_CODE: assert property (@(posedge pclk)
    disable iff (!presetn) state == ST_CHECK && ctrl[CB_SWEN] |=>
      state == ST_DONE && phasing_result_code == RC_ENABLE)
    else $error("wrong enable not reported as code 2");

  AST_LOWV: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_CHECK && low_voltage_mode |=> !motion_start)
    else $error("phasing started in low-voltage mode");

  AST_QTR_MOVE: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_MOVE1 && motion_done |=>
      motion_start && motion_kind == MK_QUARTER && motion_param == ANGLE_QTR)
    else $error("second move is not a quarter period");

  AST_T1_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    s_t1_success |=> type1_outcome_flag && phasing_result_code == RC_OK
      ##1 state == ST_IDLE && !ctrl[CB_CMD1])
    else $error("type 1 success not flagged");

  AST_DRIVE_OK: assert property (@(posedge pclk)
    disable iff (!presetn) drive_ok_flag |->
      type1_outcome_flag && type2_outcome_flag)
    else $error("drive ok without phasing outcome");

  AST_OVER: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_VIB && motion_done && vib_torque_time > TORQ_MAX |=>
      phasing_result_code == RC_OVER && !type2_outcome_flag)
    else $error("torque over 200 not reported");

  AST_CMD_CLEAR: assert property (@(posedge pclk)
    disable iff (!presetn) state == ST_DONE |=>
      !ctrl[CB_CMD1] && !ctrl[CB_CMD2])
    else $error("command bits not cleared at end");

  AST_SAVED_VIB: assert property (@(posedge pclk)
    disable iff (!presetn)
    motion_start && motion_kind == MK_VIBRATE && torque_saved_valid |->
      motion_param == torque_saved)
    else $error("vibration ignores saved torque time");

endmodule // encoder_phasing_sequencer
`default_nettype wire

// >>> enc_phase_pkg.sv
`default_nettype none
package enc_phase_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_PRI_LINES  = 8'h04;
  localparam logic [7:0] OFF_AUX_LINES  = 8'h08;
  localparam logic [7:0] OFF_POLES      = 8'h0c;
  localparam logic [7:0] OFF_RESULT     = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;
  localparam logic [7:0] OFF_TORQ_CALC  = 8'h18;
  localparam logic [7:0] OFF_TORQ_SAVED = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h24;

  // control register bit positions
  localparam int CB_CMD1 = 0;
  localparam int CB_CMD2 = 1;
  localparam int CB_SWEN = 2;
  localparam int CB_PFMT = 3;
  localparam int CB_AFMT = 4;
  localparam int CB_SAVE = 5;
  localparam int CB_SRC  = 6;
  localparam int CTRL_W  = 7;

  // status register bit positions
  localparam int SB_OUT1  = 0;
  localparam int SB_OUT2  = 1;
  localparam int SB_DOK   = 2;
  localparam int SB_BUSY  = 3;
  localparam int SB_HWEN  = 4;
  localparam int SB_SAVED = 5;
  localparam int SB_COMM  = 6;

  // interrupt bit positions
  localparam int IB_DONE1 = 0;
  localparam int IB_DONE2 = 1;
  localparam int IB_FAIL  = 2;
  localparam int IRQ_W    = 3;

  // reset values
  localparam logic [15:0] LINE_RESET  = 16'h0400;
  localparam logic [15:0] POLES_RESET = 16'h0000;

  // result codes
  localparam logic [15:0] RC_OK       = 16'h0000;
  localparam logic [15:0] RC_ENABLE   = 16'h0002;
  localparam logic [15:0] RC_POSFB    = 16'h0003;
  localparam logic [15:0] RC_COUNT    = 16'h0004;
  localparam logic [15:0] RC_NOTREADY = 16'h0005;
  localparam logic [15:0] RC_DEVIATE  = 16'h0006;
  localparam logic [15:0] RC_OVER     = 16'h0007;

  // limits
  localparam logic [15:0] TORQ_DEV_MAX = 16'h0019;
  localparam logic [15:0] TORQ_MAX     = 16'h00c8;
  localparam logic [15:0] EXP_MAX      = 16'h0012;

  // motion requests to the current loop
  localparam logic [1:0]  MK_NONE    = 2'h0;
  localparam logic [1:0]  MK_ALIGN   = 2'h1;
  localparam logic [1:0]  MK_QUARTER = 2'h2;
  localparam logic [1:0]  MK_VIBRATE = 2'h3;
  localparam logic [15:0] ANGLE_ZERO = 16'h0000;
  localparam logic [15:0] ANGLE_QTR  = 16'h4000;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CHECK = 6'h02,
    ST_MOVE1 = 6'h04,
    ST_MOVE2 = 6'h08,
    ST_VIB   = 6'h10,
    ST_DONE  = 6'h20
  } seq_state_e;

endpackage
`default_nettype wire

// >>> motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// motor and encoder on the far side of the current loop
module motor_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // motion request
  input  wire logic        motion_start,
  // behaviour chosen by the bench
  input  wire logic [7:0]  lag,
  input  wire logic [31:0] move_delta,
  input  wire logic [15:0] torq,
  // feedback
  output logic             motion_done,
  output logic [31:0]      enc_delta,
  output logic [15:0]      vib_torque_time
);
  int   cnt;
  logic busy;

  ////////////////////////////////////////////////////////////////////////////
  // moves only when told to, otherwise the shaft stays still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy        <= 1'b0;
      cnt         <= 0;
      motion_done <= 1'b0;
    end else begin
      motion_done <= 1'b0;
      if (motion_start) begin
        busy <= 1'b1;
        cnt  <= int'(lag);
      end else if (busy) begin
        if (cnt == 0) begin
          busy        <= 1'b0;
          motion_done <= 1'b1;
        end else begin
          cnt <= cnt - 1;
        end
      end
    end
  end

  // feedback valid only beside done, inverted otherwise
  assign enc_delta       = motion_done ? move_delta : ~move_delta;
  assign vib_torque_time = motion_done ? torq : ~torq;
endmodule // motor_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); \
  end \
end
module tb;
  import enc_phase_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        hw_en   = 1'b1;
  logic [15:0] fault   = 16'h0;
  logic        rdy     = 1'b1;
  logic        inr     = 1'b1;
  logic        lowv    = 1'b0;
  logic [7:0]  lag     = 8'h00;
  logic [31:0] mdelta  = 32'h64;
  logic [15:0] torq    = 16'h0;
  logic [31:0] base    = 32'h0;
  logic [31:0] prdata, edelta, rdat;
  logic [15:0] mparam, vtt, plog;
  logic [1:0]  mkind;
  logic [3:0]  klog;
  logic        pready, pslverr, mstart, mdone, ezr, cvalid, dok, irq, err;
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          n_ezr     = 0;
  int          n_mv      = 0;

  always #25 pclk = ~pclk;

  encoder_phasing_sequencer dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hardware_enable_bit(hw_en),
    .fault_code(fault), .drive_ready(rdy), .inrush_closed(inr),
    .low_voltage_mode(lowv), .motion_start(mstart), .motion_kind(mkind),
    .motion_param(mparam), .motion_done(mdone), .enc_delta(edelta),
    .vib_torque_time(vtt), .emu_zero_reset(ezr),
    .commutation_valid(cvalid), .drive_ok_flag(dok), .irq(irq));

  motor_model motor_u (
    .pclk(pclk), .presetn(presetn), .motion_start(mstart), .lag(lag),
    .move_delta(mdelta), .torq(torq), .motion_done(mdone),
    .enc_delta(edelta), .vib_torque_time(vtt));

  // log zero-reference pulses and motion requests
  always @(posedge pclk) begin
    if (ezr === 1'b1) n_ezr++;
    if (mstart === 1'b1) begin
      n_mv++;
      klog <= {klog[1:0], mkind};
      plog <= mparam;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cond(input logic h, input logic [15:0] f,
                      input logic r, input logic i, input logic l);
    hw_en <= h;
    fault <= f;
    rdy   <= r;
    inr   <= i;
    lowv  <= l;
    @(posedge pclk);
  endtask

  // one phasing command, waits for the end and checks the code
  task automatic run(input logic [31:0] cmd, input logic [15:0] code);
    int n;
    int e0;
    e0 = n_ezr;
    wr(OFF_CTRL, base | cmd);
    n = 0;
    do begin
      rd(OFF_CTRL);
      n++;
    end while (rdat[1:0] !== 2'b00 && n < 60);
    `CHK("cmd bits", 2'b00, rdat[1:0])
    `CHK("zero ref", e0 + 1, n_ezr)
    rd(OFF_RESULT);
    `CHK("result", {16'h0, code}, rdat)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(OFF_PRI_LINES);
    `CHK("pri lines", 32'h400, rdat)
    rd(OFF_AUX_LINES);
    `CHK("aux lines", 32'h400, rdat)
    rd(OFF_STATUS);
    `CHK("status", 32'h10, rdat)
    `CHK("comm", 1'b0, cvalid)
    wr(OFF_RESULT, 32'h5);
    rd(OFF_RESULT);
    `CHK("ro result", 32'h0, rdat)
    rd(8'h28);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdat)
  endtask

  task automatic t_refuse;
    base = 32'h4;
    run(32'h1, RC_ENABLE);
    base = 32'h0;
    cond(1'b0, 16'h0, 1'b1, 1'b1, 1'b0);
    run(32'h2, RC_ENABLE);
    cond(1'b1, 16'h3, 1'b1, 1'b1, 1'b0);
    run(32'h1, RC_NOTREADY);
    cond(1'b1, 16'h0, 1'b0, 1'b1, 1'b0);
    run(32'h2, RC_NOTREADY);
    cond(1'b1, 16'h0, 1'b1, 1'b0, 1'b0);
    run(32'h1, RC_NOTREADY);
    cond(1'b1, 16'h0, 1'b1, 1'b1, 1'b1);
    run(32'h2, RC_NOTREADY);
    run(32'h1, RC_NOTREADY);
    cond(1'b1, 16'h0, 1'b1, 1'b1, 1'b0);
    run(32'h1, RC_COUNT);
    `CHK("no motion", 0, n_mv)
  endtask

  task automatic t_type1;
    wr(OFF_POLES, 32'h4);
    lag <= 8'd20;
    run(32'h1, RC_OK);
    lag <= 8'd0;
    `CHK("kinds", 4'b0110, klog)
    `CHK("quarter", ANGLE_QTR, plog)
    `CHK("comm", 1'b1, cvalid)
    rd(OFF_STATUS);
    `CHK("flag1", 1'b1, rdat[SB_OUT1])
    `CHK("dok", 1'b0, dok)
    mdelta <= 32'hffffff9c;
    run(32'h1, RC_POSFB);
    wr(OFF_PRI_LINES, 32'hfc00);
    run(32'h1, RC_OK);
    mdelta <= 32'h64;
    run(32'h1, RC_POSFB);
    mdelta <= 32'h0;
    run(32'h1, RC_COUNT);
    mdelta <= 32'h64;
    base = 32'h8;
    wr(OFF_PRI_LINES, 32'h13);
    run(32'h1, RC_COUNT);
    wr(OFF_PRI_LINES, 32'h12);
    run(32'h1, RC_OK);
    base = 32'h0;
    wr(OFF_PRI_LINES, 32'h400);
    wr(OFF_AUX_LINES, 32'h0);
    run(32'h1, RC_COUNT);
    base = 32'h10;
    wr(OFF_AUX_LINES, 32'h13);
    run(32'h1, RC_COUNT);
    base = 32'h40;
    wr(OFF_AUX_LINES, 32'hfc00);
    mdelta <= 32'hffffff9c;
    run(32'h1, RC_OK);
    base = 32'h0;
  endtask

  task automatic t_type2;
    torq <= 16'hfa;
    run(32'h2, RC_OVER);
    torq <= 16'hc9;
    run(32'h2, RC_OVER);
    torq <= 16'hc8;
    run(32'h2, RC_OK);
    `CHK("vibrate", 2'b11, klog[1:0])
    `CHK("vib time", 16'h0, plog)
    `CHK("dok", 1'b1, dok)
    cond(1'b0, 16'h0, 1'b1, 1'b1, 1'b0);
    wr(OFF_CTRL, 32'h20);
    cond(1'b1, 16'h0, 1'b1, 1'b1, 1'b0);
    rd(OFF_TORQ_SAVED);
    `CHK("saved", 32'hc8, rdat)
    rd(OFF_TORQ_CALC);
    `CHK("calc", 32'hc8, rdat)
    rd(OFF_STATUS);
    `CHK("status both", 32'h77, rdat)
    torq <= 16'hab;
    run(32'h2, RC_DEVIATE);
    `CHK("dok", 1'b0, dok)
    torq <= 16'haf;
    run(32'h2, RC_OK);
    `CHK("saved time", 16'hc8, plog)
    torq <= 16'hae;
    run(32'h2, RC_DEVIATE);
  endtask

  task automatic t_irq;
    wr(OFF_IRQ_STAT, 32'h7);
    `CHK("irq idle", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h2);
    torq <= 16'hc8;
    run(32'h2, RC_OK);
    `CHK("irq done", 1'b1, irq)
    rd(OFF_IRQ_STAT);
    `CHK("irq stat", 32'h2, rdat)
    wr(OFF_IRQ_STAT, 32'h2);
    `CHK("irq clear", 1'b0, irq)
    base = 32'h4;
    run(32'h1, RC_ENABLE);
    base = 32'h0;
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_IRQ_MASK, 32'h4);
    `CHK("irq fail", 1'b1, irq)
    wr(OFF_IRQ_STAT, 32'h4);
    `CHK("irq fail clr", 1'b0, irq)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_refuse;
    t_type1;
    t_type2;
    t_irq;
    conclude;
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    conclude;
  end
endmodule // tb
`default_nettype wire
